// File: bench/count_source_model.sv
// Purpose: count pin and comparator sources facing the timer block
// Assumes: a source holds its level between bursts
// Notes:   HALF clocks per level; bursts start on a start pulse
`timescale 1ns/100ps
`default_nettype none

module count_source_model #(
  parameter HALF = 4
) (
  // clock
  input wire logic clk_sys,
  // burst control
  input wire logic start,
  input wire logic useCmp,
  input wire logic [7:0] toggles,
  // source levels
  output logic pinSrc = 1'h0,
  output logic cmpSrc = 1'h0,
  output logic busy
);
  logic [7:0] left = 8'h00;
  int ph = 0;
  assign busy = left != 8'h00;
  // toggle the chosen source every HALF clocks
  always @(posedge clk_sys)
  begin
    if (start)
      left <= toggles;
    else if (busy)
    begin
      ph <= (ph == HALF - 1) ? 0 : ph + 1;
      if (ph == HALF - 1)
      begin
        left <= left - 8'h01;
        if (useCmp)
          cmpSrc <= !cmpSrc;
        else
          pinSrc <= !pinSrc;
      end
    end
  end
endmodule // count_source_model
`default_nettype wire

// File: bench/timer0_checker.sv
// Purpose: port-level checks of bus timing and watchdog pulses
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to the top module at the foot of this file
`timescale 1ns/100ps
`default_nettype none

module timer0_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // bus
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // watchdog side
  input wire logic wdtPostTick,
  input wire logic wdtClearPulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // access completes at this edge
  wire logic grant = !waitrequest && (read || write);
  // bus handshake: exactly one wait state, idle stays waiting
  a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("waitrequest did not drop");
  a_wait_back: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  a_idle_wait: assert property (!read && !write |-> waitrequest)
    else $error("waitrequest low while idle");
  // read data contents
  a_unmapped_zero: assert property (grant && read &&
    (address[5:2] == 4'h0 || address[5:2] > 4'hA) |->
    readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (grant && read |->
    readdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  // watchdog clear and tap pulses
  a_clear_cause: assert property (grant && write &&
    byteenable[0] && address[5:2] == 4'hA |=> wdtClearPulse)
    else $error("watchdog clear pulse missing");
  a_clear_only: assert property (wdtClearPulse |->
    $past(grant && write && address[5:2] == 4'hA))
    else $error("stray watchdog clear pulse");
  a_clear_single: assert property (wdtClearPulse |=> !wdtClearPulse)
    else $error("watchdog clear pulse too long");
  a_post_single: assert property (wdtPostTick |=> !wdtPostTick)
    else $error("watchdog tap pulse too long");
endmodule // timer0_checker

bind timer0_prescaler_clock_mux timer0_checker chk (.clk_sys, .rstn,
  .address, .read, .write, .byteenable, .readdata, .waitrequest,
  .wdtPostTick, .wdtClearPulse);
`default_nettype wire

// File: bench/timer0_prescaler_clock_mux_tb.sv
// Purpose: self-checking bench for the timer/counter block
// Assumes: 250 MHz clock, one wait state per bus access
// Notes:   count sources come from count_source_model
`timescale 1ns/100ps
`default_nettype none

module timer0_prescaler_clock_mux_tb;
  logic clk_sys, rstn, read, write, wdtTick, start, useCmp;
  logic [5:0] address;
  logic [31:0] writedata;
  logic [7:0] toggles, rv;
  wire logic [31:0] readdata;
  wire logic waitrequest, pinOut, pinOe, wdtPostTick, wdtClearPulse;
  wire logic pinSrc, cmpSrc, busy;
  int failures, cmp_count, cycles, posts;
  logic [5:0] regAddr [5] = '{6'h04, 6'h1C, 6'h20, 6'h24, 6'h3C};
  logic [7:0] regExp [5] = '{8'h00, 8'h7F, 8'hFF, 8'h0F, 8'h00};
  logic [7:0] regMask [5] = '{8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF};
  // pin wire: the block wins while it drives
  wire logic pinWire = pinOe ? pinOut : pinSrc;

  timer0_prescaler_clock_mux uut (.clk_sys, .rstn, .address, .read,
    .write, .byteenable(4'hF), .writedata, .readdata, .waitrequest,
    .extCountPinIn(pinWire), .extCountPinOut(pinOut),
    .extCountPinOe(pinOe), .pinLatchData(1'h1),
    .comparatorResult(cmpSrc), .wdtTick, .wdtPostTick, .wdtClearPulse);
  count_source_model src (.clk_sys, .start, .useCmp, .toggles, .pinSrc,
    .cmpSrc, .busy);

  // clock
  initial
  begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end
  // timeout and watchdog tap counting
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (wdtPostTick === 1'h1)
      posts <= posts + 1;
    if (cycles == 40000)
    begin
      failures++;
      conclude;
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input logic [7:0] lo, hi, g);
    cmp_count++;
    if ((g >= lo && g <= hi) !== 1'h1)
    begin
      failures++;
      $display("unexpected %s: expected %h..%h, seen %h", nm, lo, hi, g);
    end
  endtask
  // one bus access; read data lands in rv
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    address <= a;
    writedata <= {24'h00_0000, d};
    write <= w;
    read <= !w;
    // wait for the grant; only the bench timeout ends a hang
    do
      @(posedge clk_sys);
    while (waitrequest !== 1'h0);
    rv = readdata[7:0];
    write <= 0;
    read <= 0;
    @(posedge clk_sys);
  endtask
  // clear the count, run a source burst, read the count
  task automatic burst(input logic c, input logic [7:0] t);
    acc(1, 6'h04, 8'h00);
    repeat (10) @(posedge clk_sys);
    useCmp <= c;
    toggles <= t;
    start <= 1;
    @(posedge clk_sys);
    start <= 0;
    do
      @(posedge clk_sys);
    while (busy !== 1'h0);
    repeat (12) @(posedge clk_sys);
    acc(0, 6'h04, 8'h00);
  endtask
  task automatic ticks(input int k);
    repeat (k)
    begin
      wdtTick <= 1;
      @(posedge clk_sys);
      wdtTick <= 0;
      @(posedge clk_sys);
    end
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic conclude;
    $display("failures %0d, comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    {rstn, read, write, address, writedata, wdtTick} = 0;
    {start, useCmp, toggles, failures, cmp_count, cycles, posts} = 0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1;
    foreach (regAddr[i])
    begin
      acc(0, regAddr[i], 8'h00);
      chk("reset value", regExp[i], rv & regMask[i]);
    end
    acc(1, 6'h24, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk("pin enable", 8'h00, {7'h00, pinOe});
    acc(1, 6'h20, 8'h08);
    acc(1, 6'h04, 8'hFE);
    chk("pin drive", 8'h03, {6'h00, pinOe, pinOut});
    acc(0, 6'h04, 8'h00);
    chk("inhibited count", 8'hFE, rv);
    repeat (36) @(posedge clk_sys);
    acc(0, 6'h04, 8'h00);
    rng("free-run count", 8'h07, 8'h09, rv - 8'hFE);
    acc(1, 6'h28, 8'h00);
    for (int r = 0; r < 8; r++)
    begin
      acc(1, 6'h20, r[7:0]);
      acc(1, 6'h04, 8'h00);
      repeat (48 << r) @(posedge clk_sys);
      acc(0, 6'h04, 8'h00);
      rng("prescaled count", 8'h04, 8'h07, rv);
    end
    acc(1, 6'h20, 8'h28);
    burst(0, 19);
    chk("rising pin edges", 8'h0A, rv);
    acc(1, 6'h20, 8'h38);
    burst(0, 19);
    chk("falling pin edges", 8'h0A, rv);
    acc(1, 6'h20, 8'h20);
    burst(0, 39);
    chk("prescaled pin edges", 8'h0A, rv);
    acc(1, 6'h20, 8'h28);
    acc(1, 6'h1C, 8'h6F);
    burst(1, 19);
    chk("comparator edges", 8'h0A, rv);
    acc(1, 6'h1C, 8'h2F);
    @(posedge clk_sys);
    chk("pin drive", 8'h03, {6'h00, pinOe, pinOut});
    burst(1, 19);
    chk("comparator edges", 8'h09, rv);
    acc(1, 6'h1C, 8'h3F);
    chk("pin enable", 8'h01, {7'h00, pinOe});
    burst(1, 19);
    chk("fed back edges", 8'h0A, rv);
    acc(1, 6'h28, 8'h00);
    acc(1, 6'h04, 8'h00);
    acc(1, 6'h20, 8'h08);
    repeat (2)
    begin
      acc(1, 6'h28, 8'h00);
      posts = 0;
      ticks(7);
      chk("watchdog taps", 8'h04, posts[7:0]);
    end
    acc(1, 6'h20, 8'h00);
    posts = 0;
    ticks(7);
    chk("watchdog taps", 8'h00, posts[7:0]);
    conclude;
  end
endmodule // timer0_prescaler_clock_mux_tb
`default_nettype wire

// File: design/_unused_placeholder_none.v
`timescale 1ns/100ps

// File: design/sync_2ff.v
// Purpose: two-flop level synchroniser for inputs from outside clk_sys
// Assumes: inputs are levels, not pulses
// Notes:   the first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none

module sync_2ff #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clk_sys,
  input wire rstn,
  // data
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1;

  // two flip-flops in series
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1 <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule // sync_2ff

`default_nettype wire

// File: design/timer0_map.vh
// Purpose: register map, field positions, reset values and timing counts
//          of the timer/counter block
// Assumes: one register per aligned 32-bit word, byte address = 4 * index
// Notes:   definitions only
`ifndef TIMER0_MAP_VH
`define TIMER0_MAP_VH

// register indices (byte address is four times the index)
`define TIMER_COUNT_IDX 4'h1
`define COMP_CTRL_IDX 4'h7
`define TIMER_CONFIG_IDX 4'h8
`define PIN_DIR_IDX 4'h9
`define WDT_CLEAR_IDX 4'hA

// timer_config fields
`define CFG_CLK_SRC_BIT 5
`define CFG_EDGE_BIT 4
`define CFG_ASSIGN_BIT 3
`define CFG_RATIO_MSB 2
`define CFG_RATIO_LSB 0

// comparator_control fields
`define CMP_RESULT_BIT 7
`define CMP_DRIVE_N_BIT 6
`define CMP_POL_BIT 5
`define CMP_CLKSEL_BIT 4
`define CMP_ON_BIT 3

// pin_direction bit of the count pin
`define PIN_DIR_CNT_BIT 2

// reset values
`define TIMER_RESET 8'h00
`define CFG_RESET 8'hFF
`define CMP_RESET 7'h7F
`define PIN_DIR_RESET 4'hF
`define PRESC_RESET 8'h00

// timing: one oscillator period per system clock
`define CLK_PERIOD_NS 4
`define TOSC_NS 4
`define TOSC_CLKS (`TOSC_NS / `CLK_PERIOD_NS)
`define TOSC_PER_INSTR 4
`define INSTR_CLKS (`TOSC_PER_INSTR * `TOSC_CLKS)
`define INHIBIT_INSTR 2
`define INHIBIT_CLKS (`INHIBIT_INSTR * `INSTR_CLKS)

`endif

// File: design/timer0_prescaler_clock_mux.v
// Purpose: 8-bit timer/counter with shared 8-bit prescaler and clock mux,
//          reached over an Avalon-MM slave with waitrequest
// Assumes: clk_sys is the oscillator, one Tosc per clock, four per
//          instruction cycle; pin and comparator inputs are asynchronous
// Notes:   watchdog itself lives outside; it feeds wdtTick and gets
//          wdtPostTick and wdtClearPulse
//
// Contract
// - source select clear, no prescaler: count once per instruction cycle.
// - any count register write blocks counting for the next two cycles.
// - source set, comparator clock select set, drive_n set: count pin edges.
// - edge select clear counts rising edges, set counts falling edges.
// - source set, comparator clock select clear: count comparator output.
// - comparator clock select set, drive_n clear: drive comparator onto pin.
// - prescaler serves timer or watchdog; assign bit clear picks timer.
// - ratio select bits set prescale ratio, 1:2 to 1:256 for timer.
// - prescaler is not software visible and resets to zero.
// - with prescaler on timer, count register writes clear it.
// - with prescaler on watchdog, watchdog clear also clears it.
// - external source is sampled on phases Q2 and Q4.
// - prescaler divides the external input ahead of sampling.
// - increment lands three to seven Tosc after the input change.
// - source select set overrides pin direction of the count pin.
// - count register is eight bits, readable and writable.
`timescale 1ns/100ps
`default_nettype none
`include "timer0_map.vh"

module timer0_prescaler_clock_mux (
  // clock and reset
  input wire clk_sys,
  input wire rstn,
  // avalon-mm slave
  input wire [5:0] address,
  input wire read,
  input wire write,
  input wire [3:0] byteenable,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  // count pin, split into input, output and enable
  input wire extCountPinIn,
  output reg extCountPinOut,
  output reg extCountPinOe,
  // port latch value driven when the pin is a plain output
  input wire pinLatchData,
  // comparator digital result, asynchronous
  input wire comparatorResult,
  // watchdog side
  input wire wdtTick,
  output reg wdtPostTick,
  output reg wdtClearPulse
);

  // inhibit length in clocks, cut to the counter's width on purpose
  localparam [31:0] INHIBIT_WIDE = `INHIBIT_CLKS;
  localparam [3:0] INHIBIT_LOAD = INHIBIT_WIDE[3:0];
  localparam [1:0] PHASE_Q2 = 2'h1;
  localparam [1:0] PHASE_Q4 = 2'h3;

  // registers
  reg [7:0] timerCount;
  reg [7:0] timerConfig;
  reg [6:0] compCtrl;
  reg [3:0] pinDirection;
  reg [7:0] presc;
  reg [1:0] phase;
  reg [3:0] inhibitCnt;
  reg prevLevel;
  reg prevPresBit;
  reg sampA;
  reg sampB;

  // synchronised inputs
  wire pinSync;
  wire cmpSync;

  // decoded fields and strobes
  wire [3:0] regIdx;
  wire accessPhase;
  wire wrLane0;
  wire timerWr;
  wire wdtClrWr;
  wire clkSrcSel;
  wire edgeSel;
  wire presToTimer;
  wire [2:0] ratioSel;
  wire cmpOn;
  wire effClkSel;
  wire effDriveN;
  wire comparator_result;
  wire srcRaw;
  wire srcLevel;
  wire extEdge;
  wire instrTick;
  wire strobe;
  wire presBit;
  wire presRise;
  wire presInc;
  wire presClr;
  wire samplerIn;
  wire samplerRise;
  wire countEvent;
  wire countOk;

  reg [31:0] next_readdata;

  // pin and comparator result pass two flops before any logic
  // both come from outside clk_sys and may change at any time
  sync_2ff #(.WIDTH(2)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .asyncIn({extCountPinIn, comparatorResult}),
    .syncOut({pinSync, cmpSync})
  );

  // bus decode
  assign regIdx = address[5:2];
  assign accessPhase = waitrequest & (read | write);
  assign wrLane0 = write & ~waitrequest & byteenable[0];
  assign timerWr = wrLane0 & (regIdx == `TIMER_COUNT_IDX);
  assign wdtClrWr = wrLane0 & (regIdx == `WDT_CLEAR_IDX);

  // configuration fields
  assign clkSrcSel = timerConfig[`CFG_CLK_SRC_BIT];
  assign edgeSel = timerConfig[`CFG_EDGE_BIT];
  assign presToTimer = ~timerConfig[`CFG_ASSIGN_BIT];
  assign ratioSel = timerConfig[`CFG_RATIO_MSB:`CFG_RATIO_LSB];

  // clock select and drive_n only act while the comparator is on
  assign cmpOn = compCtrl[`CMP_ON_BIT];
  assign effClkSel = compCtrl[`CMP_CLKSEL_BIT] | ~cmpOn;
  assign effDriveN = compCtrl[`CMP_DRIVE_N_BIT] | ~cmpOn;
  assign comparator_result = cmpSync ^ ~compCtrl[`CMP_POL_BIT];

  // external source: comparator internally, else the pin (which carries
  // the comparator output itself when it is driven back onto the pin)
  assign srcRaw = effClkSel ? pinSync : comparator_result;
  assign srcLevel = srcRaw ^ edgeSel;
  assign extEdge = srcLevel & ~prevLevel;

  // instruction phases: Q1..Q4 as phase 0..3
  assign instrTick = (phase == PHASE_Q4);
  assign strobe = (phase == PHASE_Q2) | (phase == PHASE_Q4);

  // prescaler tap: code n selects bit n, a divide by 2 to the n+1
  assign presBit = presc[ratioSel];
  assign presRise = presBit & ~prevPresBit;

  // prescaler input and clear
  assign presInc = presToTimer ? (clkSrcSel ? extEdge : instrTick)
                               : wdtTick;
  assign presClr = (timerWr & presToTimer)
                 | (wdtClrWr & ~presToTimer);

  // sampler sees the prescaler output or the edge-selected level
  assign samplerIn = presToTimer ? presBit : srcLevel;
  assign samplerRise = strobe & sampA & ~sampB;

  // counting event per mode
  assign countEvent = clkSrcSel ? samplerRise
                    : (presToTimer ? presRise : instrTick);
  assign countOk = (inhibitCnt == 4'h0);

  // instruction phase counter
  // runs from reset release; Q4 falls on every fourth clock
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      phase <= 2'h0;
    else
      phase <= phase + 2'h1;
  end

  // edge history for the external level and the prescaler tap; the
  // level history resets high, the level that the reset setting of
  // the edge select gives an idle-low source, so release is edge free
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      prevLevel <= 1'b1;
      prevPresBit <= 1'b0;
    end
    else
    begin
      prevLevel <= srcLevel;
      prevPresBit <= presBit;
    end
  end

  // two sampling stages on Q2 and Q4; both reset high for the same
  // reason as the level history, so no count follows release
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sampA <= 1'b1;
      sampB <= 1'b1;
    end
    else if (strobe)
    begin
      sampA <= samplerIn;
      sampB <= sampA;
    end
  end

  // prescaler: hidden from software, clear wins over counting
  // a count that meets a clear is dropped, so a clear always leaves zero
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      presc <= `PRESC_RESET;
    else if (presClr)
      presc <= `PRESC_RESET;
    else if (presInc)
      presc <= presc + 8'h01;
  end

  // inhibit window after a count register write
  // an event that falls inside the window is lost, not deferred
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      inhibitCnt <= 4'h0;
    else if (timerWr)
      inhibitCnt <= INHIBIT_LOAD;
    else if (!countOk)
      inhibitCnt <= inhibitCnt - 4'h1;
  end

  // count register: software write wins over an increment
  // an event in the cycle of the write is lost with the old value
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      timerCount <= `TIMER_RESET;
    else if (timerWr)
      timerCount <= writedata[7:0];
    else if (countEvent && countOk)
      timerCount <= timerCount + 8'h01;
  end

  // software configuration registers
  // only byte lane 0 carries register bits; other lanes are ignored
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      timerConfig <= `CFG_RESET;
      compCtrl <= `CMP_RESET;
      pinDirection <= `PIN_DIR_RESET;
    end
    else if (wrLane0)
    begin
      case (regIdx)
        `TIMER_CONFIG_IDX: timerConfig <= writedata[7:0];
        `COMP_CTRL_IDX: compCtrl <= writedata[6:0]; // result bit read-only
        `PIN_DIR_IDX: pinDirection <= writedata[3:0];
        default: timerConfig <= timerConfig;
      endcase
    end
  end

  // read mux, unmapped words read as zero
  // the comparator result is read live and cannot be written
  always @*
  begin
    next_readdata = 32'h0000_0000;
    case (regIdx)
      `TIMER_COUNT_IDX: next_readdata[7:0] = timerCount;
      `COMP_CTRL_IDX: next_readdata[7:0] = {comparator_result, compCtrl};
      `TIMER_CONFIG_IDX: next_readdata[7:0] = timerConfig;
      `PIN_DIR_IDX: next_readdata[3:0] = pinDirection;
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  // one wait cycle per access, data registered with the grant
  // a fresh request is taken only once waitrequest is back high
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end
    else
    begin
      waitrequest <= ~accessPhase;
      if (accessPhase && read)
        readdata <= next_readdata;
    end
  end

  // count pin drive: comparator output, else input when counting,
  // else the direction register
  // the pin input stays live while the comparator drives it
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      extCountPinOut <= 1'b0;
      extCountPinOe <= 1'b0;
    end
    else if (!effDriveN)
    begin
      extCountPinOut <= comparator_result;
      extCountPinOe <= 1'b1;
    end
    else if (clkSrcSel)
    begin
      extCountPinOut <= 1'b0;
      extCountPinOe <= 1'b0;
    end
    else
    begin
      extCountPinOut <= pinLatchData;
      extCountPinOe <= ~pinDirection[`PIN_DIR_CNT_BIT];
    end
  end

  // watchdog side: postscaled tick and clear pulse
  // no tap pulse in the cycle of a clear, the count starts over
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      wdtPostTick <= 1'b0;
      wdtClearPulse <= 1'b0;
    end
    else
    begin
      wdtPostTick <= ~presToTimer & presRise & ~presClr;
      wdtClearPulse <= wdtClrWr;
    end
  end

endmodule // timer0_prescaler_clock_mux

`default_nettype wire
